// File: bench/ifpb_host.sv
// Host model that clocks 32-bit words into the serial programming port.
`timescale 1ns/1ns
`default_nettype none
module ifpb_host (
	input  wire logic clk_sys,
	output var logic  spi_clk,
	output var logic  spi_data,
	output var logic  spi_le
);
	initial begin
		spi_clk = 1'b0;
		spi_data = 1'b0;
		spi_le = 1'b1;
	end

	// Every pin level stands four system clocks, above the three the port needs.
	task automatic hold();
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : hold

	// word framing: n bits, bit 0 first, then a rising latch enable.
	task automatic send(input logic [31:0] w, input int n);
		hold();
		spi_le = 1'b0;
		for (int i = 0; i < n; i++) begin
			// Bits past the top of the word go out as zero.
			spi_data = (i < 32) ? w[i] : 1'b0;
			spi_clk = 1'b0;
			hold();
			spi_clk = 1'b1;
			hold();
		end
		spi_clk = 1'b0;
		spi_data = ~spi_data;
		hold();
		spi_le = 1'b1;
		hold();
	endtask : send
endmodule : ifpb_host
`default_nettype wire

// File: bench/ifpb_top_test.sv
// Self-checking bench for the power and bias control word.
`timescale 1ns/1ns
`default_nettype none
module ifpb_top_test;
	import ifpb_pkg::*;
	logic              clk_sys;
	logic              rst;
	wire               spi_clk;
	wire               spi_data;
	wire               spi_le;
	ifpb_ctrl_s        ctrl_q;
	logic              cal_busy_q;
	logic              cal_pulse_q;
	logic [WORD_W-1:0] word_view_q;
	logic              tx_common_mode_select_q;
	int                failures;
	int                n_compared;
	int                cycles;

	ifpb_top uut (.clk_sys(clk_sys), .rst(rst), .spi_clk(spi_clk), .spi_data(spi_data),
		.spi_le(spi_le), .ctrl_q(ctrl_q), .cal_busy_q(cal_busy_q),
		.cal_pulse_q(cal_pulse_q), .word_view_q(word_view_q),
		.tx_common_mode_select_q(tx_common_mode_select_q));
	ifpb_host u_host (.clk_sys(clk_sys), .spi_clk(spi_clk), .spi_data(spi_data),
		.spi_le(spi_le));

	task automatic stop_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	// Expected field bundle, bit 5 in the top position down to bits 30..25.
	function automatic logic [25:0] fields(input logic [31:0] w);
		return {w[5], w[6], w[8:7], w[11:9], w[16:12], w[20:17], w[21], w[22], w[23],
			w[24], w[30:25]};
	endfunction : fields

	task automatic write_check(input logic [31:0] w, input logic [31:0] exp);
		u_host.send(w, 32);
		repeat (6) @(posedge clk_sys);
		#1;
		check(word_view_q, exp, "stored word");
		check(32'(ctrl_q), 32'(fields(exp)), "decoded fields");
	endtask : write_check

	task automatic t_reset();
		check(word_view_q, 32'h0060_991C, "power-on word");
		check(32'(ctrl_q), 32'(fields(32'h0060_991C)), "power-on fields");
		check(32'(cal_busy_q), 32'h0000_0000, "idle calibration");
		check(32'(tx_common_mode_select_q), 32'h0000_0000, "power-on common mode");
	endtask : t_reset

	task automatic t_fields();
		// reserved bit zero: every control word below keeps bit 31 clear.
		write_check(32'h7FFE_FFDC, 32'h7FFE_FFDC);
		write_check(32'h2AAA_AA9C, 32'h2AAA_AA9C);
		write_check(32'h5555_555C, 32'h5555_555C);
		write_check(32'h0001_041C, 32'h0001_041C);
		write_check(32'h0000_701C, 32'h0000_701C);
	endtask : t_fields

	task automatic t_refuse();
		write_check(32'h7FFE_FFDD, 32'h0000_701C);
		write_check(32'h7FFE_FFCC, 32'h0000_701C);
		u_host.send(32'h7FFE_FFDC, 31);
		repeat (6) @(posedge clk_sys);
		#1;
		check(word_view_q, 32'h0000_701C, "short word ignored");
		// A 33-bit frame whose last 32 bits would form a matching word.
		u_host.send(32'h7FFD_FFB8, 33);
		repeat (6) @(posedge clk_sys);
		#1;
		check(word_view_q, 32'h0000_701C, "long word ignored");
	endtask : t_refuse

	task automatic t_txcm();
		u_host.send(32'hA080_001B, 32);
		repeat (6) @(posedge clk_sys);
		#1;
		check(32'(tx_common_mode_select_q), 32'h0000_0001, "internal common mode");
		check(word_view_q, 32'h0000_701C, "other word untouched");
		u_host.send(32'h2080_001B, 32);
		repeat (6) @(posedge clk_sys);
		#1;
		check(32'(tx_common_mode_select_q), 32'h0000_0000, "external common mode");
	endtask : t_txcm

	task automatic t_cal();
		int np;
		int nb;
		np = 0;
		nb = 0;
		fork
			u_host.send(32'h0060_993C, 32);
		join_none
		repeat (400) begin
			@(posedge clk_sys);
			#1;
			np += int'(cal_pulse_q);
			nb += int'(cal_busy_q);
		end
		check(32'(np), 32'h0000_0001, "start pulse count");
		check(32'(nb), 32'(CAL_CYCLES), "calibration length");
		check(word_view_q, WORD_RESET, "start bit cleared");
	endtask : t_cal

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end

	initial begin
		failures = 0;
		n_compared = 0;
		cycles = 0;
		rst = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		t_reset();
		rst = 1'b0;
		t_fields();
		t_refuse();
		t_txcm();
		t_cal();
		stop_test();
	end
endmodule : ifpb_top_test
`default_nettype wire

// File: common/ifpb_pkg.sv
// Package with the control word layout, reset values and serial port constants.
package ifpb_pkg;
	localparam int          WORD_W          = 32;
	localparam int          CNT_W           = 6;
	localparam logic [4:0]  SEL_CODE        = 5'h1C;
	localparam int          SEL_LSB         = 0;
	localparam int          SEL_MSB         = 4;
	localparam int          CAL_BIT         = 5;
	localparam int          BIAS_SEL_BIT    = 6;
	localparam int          BIAS_LSB        = 7;
	localparam int          GAIN_LSB        = 9;
	localparam int          VGA_LSB         = 12;
	localparam int          TX_OFF_LSB      = 17;
	localparam int          TEMP_ADC_BIT    = 21;
	localparam int          TEMP_SENS_BIT   = 22;
	localparam int          RX_LOOP_BIT     = 23;
	localparam int          XAMP_OFF_BIT    = 24;
	localparam int          RX_OFF_LSB      = 25;
	localparam int          RSV_BIT         = 31;
	localparam logic [31:0] WORD_RESET      = 32'h0060_991C;
	localparam logic [4:0]  TXCM_SEL_CODE   = 5'h1B;
	localparam int          TXCM_BIT        = 31;
	localparam logic        TXCM_RESET      = 1'b0;
	localparam int          CAL_CYCLES      = 64;
	localparam logic [6:0]  CAL_CYCLES_W    = 7'h40;
	localparam logic [5:0]  BIT_LAST        = 6'h1F;

	typedef struct packed {
		logic       temp_converter_cal_start;
		logic       xamp_bias_type_select;
		logic [1:0] xamp_bias_level;
		logic [2:0] xamp_gain_level;
		logic [4:0] rx_vga_bias_level;
		logic [3:0] tx_chain_off;
		logic       temp_converter_off;
		logic       temp_sensor_off;
		logic       rx_offset_loop_off;
		logic       xamp_off;
		logic [5:0] rx_chain_off;
	} ifpb_ctrl_s;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_RUN  = 3'b010,
		CAL_DONE = 3'b100
	} ifpb_cal_e;
endpackage : ifpb_pkg

// File: rtl/ifpb_shift.sv
// Serial word receiver: synchronises the pins and assembles 32-bit words.
`timescale 1ns/1ns
`default_nettype none
module ifpb_shift
	import ifpb_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              spi_clk,
	input  wire logic              spi_data,
	input  wire logic              spi_le,
	output logic                   word_valid_q,
	output logic [WORD_W-1:0]      word_q
);
	logic [1:0]        clk_s_q, dat_s_q, le_s_q;
	logic              clk_p_q, le_p_q;
	logic [WORD_W-1:0] sh_q, sh_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic              valid_d;
	logic [WORD_W-1:0] word_d;
	logic              rise, le_rise;

	assign rise    = clk_s_q[1] & ~clk_p_q;
	assign le_rise = le_s_q[1] & ~le_p_q;

	always_comb begin
		sh_d    = sh_q;
		cnt_d   = cnt_q;
		valid_d = 1'b0;
		word_d  = word_q;
		// Bits arrive bit 0 first while the latch enable is low.
		if (rise && !le_s_q[1]) begin
			sh_d = {dat_s_q[1], sh_q[WORD_W-1:1]};
			// The count stops at 33 so that a longer frame never reads back as 32.
			if (cnt_q <= BIT_LAST + 6'h01)
				cnt_d = cnt_q + 6'h01;
		end
		if (le_rise) begin
			valid_d = (cnt_q == 6'h20);
			word_d  = sh_q;
			cnt_d   = 6'h00;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clk_s_q      <= 2'h0;
			dat_s_q      <= 2'h0;
			// The latch enable idles high, so its history starts high to avoid a false edge.
			le_s_q       <= 2'h3;
			clk_p_q      <= 1'b0;
			le_p_q       <= 1'b1;
			sh_q         <= 32'h0000_0000;
			cnt_q        <= 6'h00;
			word_valid_q <= 1'b0;
			word_q       <= 32'h0000_0000;
		end else begin
			clk_s_q      <= {clk_s_q[0], spi_clk};
			dat_s_q      <= {dat_s_q[0], spi_data};
			le_s_q       <= {le_s_q[0], spi_le};
			clk_p_q      <= clk_s_q[1];
			le_p_q       <= le_s_q[1];
			sh_q         <= sh_d;
			cnt_q        <= cnt_d;
			word_valid_q <= valid_d;
			word_q       <= word_d;
		end
	end
endmodule : ifpb_shift
`default_nettype wire

// File: rtl/ifpb_top.sv
// Power and bias control word of the IF transceiver behind the serial port.
//
// Behaviour
// - A one in the transmit common-mode select bit means internal common-mode generation.
// - Writing one to bit 5 starts temperature converter calibration, which powers on at 0.
// - Bit 6 picks temperature-proportional bias when one and constant bias when zero.
// - Bits 7 to 8 give the output amplifier bias level, powering on as bit 8 only.
// - Bits 9 to 11 give the output amplifier gain, powering on with only bit 11 set.
// - Bits 12 to 16 give the receive VGA bias, powering on with bits 12 and 15 set.
// - Bits 17 to 20 switch off modulator, attenuator, driver and output amplifier.
// - Bits 21 and 22 switch off the temperature converter and sensor, both off at power on.
// - Bits 23 and 24 switch off the receive offset loop and the output amplifier.
// - Bits 25 to 30 switch off LNA, three VGA stages, demodulator and baseband.
`timescale 1ns/1ns
`default_nettype none
module ifpb_top
	import ifpb_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              spi_clk,
	input  wire logic              spi_data,
	input  wire logic              spi_le,
	output ifpb_ctrl_s             ctrl_q,
	output logic                   cal_busy_q,
	output logic                   cal_pulse_q,
	output logic [WORD_W-1:0]      word_view_q,
	output logic                   tx_common_mode_select_q
);
	logic              wv;
	logic [WORD_W-1:0] w;
	logic [WORD_W-1:0] reg_q, reg_d;
	ifpb_ctrl_s        ctrl_d;
	ifpb_cal_e         cal_q, cal_d;
	logic [6:0]        cc_q, cc_d;
	logic              busy_d, pulse_d;
	logic              hit;
	logic              cm_hit;
	logic              cm_d;

	ifpb_shift u_shift (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.spi_clk      (spi_clk),
		.spi_data     (spi_data),
		.spi_le       (spi_le),
		.word_valid_q (wv),
		.word_q       (w)
	);

	function automatic ifpb_ctrl_s decode(input logic [WORD_W-1:0] r);
		ifpb_ctrl_s c;
		c.temp_converter_cal_start = r[CAL_BIT];
		c.xamp_bias_type_select = r[BIAS_SEL_BIT];
		c.xamp_bias_level = r[BIAS_LSB +: 2];
		c.xamp_gain_level = r[GAIN_LSB +: 3];
		c.rx_vga_bias_level = r[VGA_LSB +: 5];
		c.tx_chain_off = r[TX_OFF_LSB +: 4];
		c.temp_converter_off = r[TEMP_ADC_BIT];
		c.temp_sensor_off = r[TEMP_SENS_BIT];
		c.rx_offset_loop_off = r[RX_LOOP_BIT];
		c.xamp_off = r[XAMP_OFF_BIT];
		c.rx_chain_off = r[RX_OFF_LSB +: 6];
		return c;
	endfunction : decode

	assign hit = wv && (w[SEL_MSB:SEL_LSB] == SEL_CODE);

	// common-mode select
	// The select sits in the neighbouring word; a one keeps the generator internal.
	assign cm_hit = wv && (w[SEL_MSB:SEL_LSB] == TXCM_SEL_CODE);

	always_comb begin
		cm_d = tx_common_mode_select_q;
		if (cm_hit)
			cm_d = w[TXCM_BIT];
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_common_mode_select_q <= TXCM_RESET;
		end else begin
			tx_common_mode_select_q <= cm_d;
		end
	end

	always_comb begin
		reg_d   = reg_q;
		cal_d   = cal_q;
		cc_d    = cc_q;
		pulse_d = 1'b0;
		if (hit) begin
			reg_d = w;
			reg_d[RSV_BIT] = 1'b0;
		end
		// calibration start
		// A start that lands while calibrating is stored but does not restart the count.
		case (cal_q)
			CAL_IDLE: begin
				if (hit && w[CAL_BIT]) begin
					cal_d   = CAL_RUN;
					cc_d    = CAL_CYCLES_W;
					pulse_d = 1'b1;
				end
			end
			CAL_RUN: begin
				cc_d = cc_q - 7'h01;
				if (cc_q == 7'h01)
					cal_d = CAL_DONE;
			end
			CAL_DONE: begin
				// A new start in the closing cycle wins over the self-clear and runs again.
				if (hit && w[CAL_BIT]) begin
					cal_d   = CAL_RUN;
					cc_d    = CAL_CYCLES_W;
					pulse_d = 1'b1;
				end else begin
					reg_d[CAL_BIT] = 1'b0;
					cal_d          = CAL_IDLE;
				end
			end
			default: cal_d = CAL_IDLE;
		endcase
		busy_d = (cal_d == CAL_RUN);
		ctrl_d = decode(reg_d);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_q       <= WORD_RESET;
			ctrl_q      <= decode(WORD_RESET);
			cal_q       <= CAL_IDLE;
			cc_q        <= 7'h00;
			cal_busy_q  <= 1'b0;
			cal_pulse_q <= 1'b0;
			word_view_q <= WORD_RESET;
		end else begin
			reg_q       <= reg_d;
			ctrl_q      <= ctrl_d;
			cal_q       <= cal_d;
			cc_q        <= cc_d;
			cal_busy_q  <= busy_d;
			cal_pulse_q <= pulse_d;
			word_view_q <= reg_d;
		end
	end

	a_latch_match: assert property (@(posedge clk_sys) disable iff (rst)
		(wv && w[4:0] != SEL_CODE) |=> $stable(word_view_q[30:6]))
		else $error("foreign word latched");
	a_latch_take: assert property (@(posedge clk_sys) disable iff (rst)
		(wv && w[4:0] == SEL_CODE) |=> word_view_q[30:6] == $past(w[30:6]))
		else $error("word not taken");
	a_rsv_zero: assert property (@(posedge clk_sys) disable iff (rst)
		word_view_q[31] == 1'b0)
		else $error("reserved bit set");
	a_cal_start: assert property (@(posedge clk_sys) disable iff (rst)
		(hit && w[CAL_BIT] && cal_q != CAL_RUN) |=> cal_pulse_q ##1 cal_busy_q[*8])
		else $error("cal not started");
	a_cal_ends: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(cal_busy_q) |-> ##[1:70] !cal_busy_q)
		else $error("cal never ends");
	a_cal_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		cal_pulse_q |=> !cal_pulse_q)
		else $error("start pulse too long");
	a_cal_clear: assert property (@(posedge clk_sys) disable iff (rst)
		(cal_q == CAL_DONE && !(hit && w[CAL_BIT])) |=> !word_view_q[CAL_BIT])
		else $error("start bit not cleared");
	a_txoff_map: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q.tx_chain_off == word_view_q[20:17])
		else $error("tx off mismatch");
	a_rxoff_map: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q.rx_chain_off == word_view_q[30:25])
		else $error("rx off mismatch");
	a_temp_map: assert property (@(posedge clk_sys) disable iff (rst)
		{ctrl_q.temp_sensor_off, ctrl_q.temp_converter_off} == word_view_q[22:21])
		else $error("temp off mismatch");
	a_loop_map: assert property (@(posedge clk_sys) disable iff (rst)
		{ctrl_q.xamp_off, ctrl_q.rx_offset_loop_off} == word_view_q[24:23])
		else $error("loop off mismatch");
	a_bias_map: assert property (@(posedge clk_sys) disable iff (rst)
		{ctrl_q.rx_vga_bias_level, ctrl_q.xamp_gain_level, ctrl_q.xamp_bias_level,
		 ctrl_q.xamp_bias_type_select} == word_view_q[16:6])
		else $error("bias mismatch");
	a_level_map: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q.xamp_bias_level == word_view_q[8:7])
		else $error("bias level mismatch");
	a_gain_map: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q.xamp_gain_level == word_view_q[11:9])
		else $error("gain mismatch");
	a_vga_map: assert property (@(posedge clk_sys) disable iff (rst)
		ctrl_q.rx_vga_bias_level == word_view_q[16:12])
		else $error("vga bias mismatch");
	a_txcm_take: assert property (@(posedge clk_sys) disable iff (rst)
		cm_hit |=> tx_common_mode_select_q == $past(w[TXCM_BIT]))
		else $error("common-mode select not taken");
	a_txcm_hold: assert property (@(posedge clk_sys) disable iff (rst)
		!cm_hit |=> $stable(tx_common_mode_select_q))
		else $error("common-mode select changed");
	c_word_hit: cover property (@(posedge clk_sys) disable iff (rst) hit);
	c_cal_done: cover property (@(posedge clk_sys) disable iff (rst) cal_q == CAL_DONE);
	c_word_miss: cover property (@(posedge clk_sys) disable iff (rst) wv && !hit);
	c_txcm_hit: cover property (@(posedge clk_sys) disable iff (rst) cm_hit);
	c_txcm_set: cover property (@(posedge clk_sys) disable iff (rst) cm_hit && w[TXCM_BIT]);
endmodule : ifpb_top
`default_nettype wire
